//--- fcs_pkg.sv
// Constants for the fieldbus command and status word block
// Overview of operation
// - Status bit 0 is one when ready to switch on, else zero.
// - Status bit 8 is one while actual value is within tolerance of reference.
// - Status bit 9 is one for remote control, zero for local.
// - Status bit 10 is one when actual magnitude reaches the supervision limit.
// - Status bit 12 is one while external run enable is received.
// - Status bit 13 is one for external location two, zero for one.
// - Status bit 14 toggles with 500 ms period; controller echoes it in command bit 14.
// - Main command bits other than heartbeat bit 14 act only while the fieldbus is the control location.
// - Data sets hold three 16-bit words; command and status are word one.
package fcs_pkg;
   localparam int WORD_W = 16;
   localparam int WORDS_PER_SET = 3;
   localparam logic [1:0] SET_MAIN_REF = 2'h1;
   localparam logic [1:0] SET_AUX_REF = 2'h3;
   localparam logic [1:0] WORD_FIRST = 2'h0;
   // Main command word fields
   localparam int CW_DRIVE_ENABLE = 0;
   localparam int CW_START = 3;
   localparam int CW_DIRECTION = 4;
   localparam int CW_CONST_SPD1 = 5;
   localparam int CW_CONST_SPD2 = 6;
   localparam int CW_FAULT_RESET = 7;
   localparam int CW_HEARTBEAT = 14;
   localparam logic [15:0] CW_USED_MASK = 16'h40f9;
   // Pump command word fields
   localparam int PC_LOCATION = 0;
   localparam int PC_PUMP_ENABLE = 1;
   localparam int PC_PUMP_FAULT_RESET = 2;
   localparam int PC_RUNTIME_RESET = 3;
   localparam int PC_LEVEL_LOOP = 4;
   localparam logic [15:0] PC_USED_MASK = 16'h001f;
   // Status word fields
   localparam int SW_READY_ON = 0;
   localparam int SW_READY_RUN = 1;
   localparam int SW_OP_ENABLED = 2;
   localparam int SW_FAULT = 3;
   localparam int SW_COAST_INACTIVE = 4;
   localparam int SW_QUICK_INACTIVE = 5;
   localparam int SW_SWITCH_INHIBIT = 6;
   localparam int SW_ALARM = 7;
   localparam int SW_TOLERANCE = 8;
   localparam int SW_REMOTE = 9;
   localparam int SW_SUPERVISION = 10;
   localparam int SW_NO_FAULT = 11;
   localparam int SW_RUN_ENABLE = 12;
   localparam int SW_LOCATION = 13;
   localparam int SW_HEARTBEAT = 14;
   localparam int SW_RESERVED = 15;
   // Reset values
   localparam logic [15:0] CW_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SW_RESET = 16'h0000;
   // Heartbeat timing
   localparam longint unsigned CLK_HZ = 64'd25000000;
   localparam longint unsigned HB_PERIOD_MS = 64'd500;
   localparam longint unsigned HB_HALF_CYCLES = (HB_PERIOD_MS * CLK_HZ) / 64'd2000;
endpackage : fcs_pkg

//--- fcs_heartbeat.sv
// Heartbeat square wave divider
`timescale 1ns/1ns
`default_nettype none
module fcs_heartbeat #(
   parameter int HALF_CYCLES = int'(fcs_pkg::HB_HALF_CYCLES)
) (
   input wire logic clk,
   input wire logic rst,
   output logic wave,
   output logic tick
);
   localparam int CNT_W = (HALF_CYCLES > 2) ? $clog2(HALF_CYCLES) : 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYCLES - 1);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic wave_reg;
   logic wave_next;

   generate
      if (HALF_CYCLES < 2) begin : g_bad
         $error("HALF_CYCLES must be at least 2");
      end
   endgenerate

   assign tick = (cnt_reg == LAST);
   assign cnt_next = tick ? '0 : cnt_reg + CNT_W'(1);
   assign wave_next = tick ? ~wave_reg : wave_reg;
   assign wave = wave_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         wave_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         wave_reg <= wave_next;
      end
   end

   logic [CNT_W:0] hold_cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_cnt <= '0;
      end else if (wave_next != wave_reg) begin
         hold_cnt <= '0;
      end else begin
         hold_cnt <= hold_cnt + (CNT_W+1)'(1);
      end
   end

   a_wave_half: assert property (@(posedge clk) disable iff (rst)
      (wave != $past(wave)) |-> ($past(hold_cnt) == (CNT_W+1)'(HALF_CYCLES - 1)))
      else $error("Heartbeat half period wrong");
   a_wave_bound: assert property (@(posedge clk) disable iff (rst)
      hold_cnt < (CNT_W+1)'(HALF_CYCLES))
      else $error("Heartbeat held too long");
endmodule : fcs_heartbeat
`default_nettype wire

//--- fcs_top.sv
// Fieldbus command word decode and drive status word assembly
`timescale 1ns/1ns
`default_nettype none
module fcs_top #(
   parameter int HB_HALF_CYCLES = int'(fcs_pkg::HB_HALF_CYCLES)
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic RX_VALID,
   input wire logic [1:0] RX_SET,
   input wire logic [1:0] RX_INDEX,
   input wire logic [15:0] RX_WORD,
   input wire logic FIELDBUS_ACTIVE,
   input wire logic READY_ON,
   input wire logic READY_RUN,
   input wire logic OP_ENABLED,
   input wire logic FAULT_FLAG,
   input wire logic COAST_STOP_INACTIVE,
   input wire logic QUICK_STOP_INACTIVE,
   input wire logic SWITCH_ON_INHIBITED,
   input wire logic ALARM,
   input wire logic [15:0] ACTUAL_VALUE,
   input wire logic [15:0] REFERENCE_VALUE,
   input wire logic [15:0] TOLERANCE,
   input wire logic [15:0] SUPERVISION_LIMIT,
   input wire logic REMOTE_CONTROL,
   input wire logic EXT_RUN_ENABLE,
   output logic [15:0] STATUS_WORD,
   output logic DRIVE_ENABLE,
   output logic START_CMD,
   output logic DIRECTION,
   output logic [1:0] CONST_SPEED_SEL,
   output logic FAULT_RESET,
   output logic HEARTBEAT_ECHO,
   output logic EXTERNAL_LOCATION_SELECT,
   output logic PUMP_ENABLE,
   output logic PUMP_FAULT_RESET,
   output logic RUNTIME_RESET,
   output logic FLUID_LEVEL_LOOP_ENABLE
);
   logic [15:0] drive_cmd_reg;
   logic [15:0] drive_cmd_next;
   logic [15:0] pump_cmd_reg;
   logic [15:0] pump_cmd_next;
   logic [15:0] status_reg;
   logic [6:0] gated_reg;
   logic [6:0] gated_next;
   logic hb_wave;
   logic hb_tick;
   wire [15:0] status_next;
   wire main_hit;
   wire aux_hit;
   wire signed [16:0] act_ext;
   wire signed [16:0] ref_ext;
   wire signed [16:0] diff;
   wire [16:0] abs_diff;
   wire [16:0] abs_act;
   wire in_tol;
   wire over_limit;

   generate
      if (fcs_pkg::WORD_W != 16) begin : g_bad
         $error("Words are 16 bits wide");
      end
   endgenerate

   fcs_heartbeat #(
      .HALF_CYCLES(HB_HALF_CYCLES)
   ) u_hb (
      .clk(CLK),
      .rst(RST),
      .wave(hb_wave),
      .tick(hb_tick)
   );

   // Word one of the main and auxiliary reference sets
   assign main_hit = RX_VALID && (RX_SET == fcs_pkg::SET_MAIN_REF)
      && (RX_INDEX == fcs_pkg::WORD_FIRST);
   assign aux_hit = RX_VALID && (RX_SET == fcs_pkg::SET_AUX_REF)
      && (RX_INDEX == fcs_pkg::WORD_FIRST);
   assign drive_cmd_next = main_hit ? (RX_WORD & fcs_pkg::CW_USED_MASK) : drive_cmd_reg;
   assign pump_cmd_next = aux_hit ? (RX_WORD & fcs_pkg::PC_USED_MASK) : pump_cmd_reg;

   // Main command fields other than heartbeat bit 14 take effect only under fieldbus control
   assign gated_next = FIELDBUS_ACTIVE ? {
      drive_cmd_reg[fcs_pkg::CW_FAULT_RESET],
      drive_cmd_reg[fcs_pkg::CW_CONST_SPD2],
      drive_cmd_reg[fcs_pkg::CW_CONST_SPD1],
      drive_cmd_reg[fcs_pkg::CW_DIRECTION],
      drive_cmd_reg[fcs_pkg::CW_START],
      drive_cmd_reg[fcs_pkg::CW_DRIVE_ENABLE],
      1'b1} : 7'h00;

   // Tolerance and supervision comparisons on signed values
   assign act_ext = $signed({ACTUAL_VALUE[15], ACTUAL_VALUE});
   assign ref_ext = $signed({REFERENCE_VALUE[15], REFERENCE_VALUE});
   assign diff = act_ext - ref_ext;
   assign abs_diff = diff[16] ? 17'(-diff) : 17'(diff);
   assign abs_act = act_ext[16] ? 17'(-act_ext) : 17'(act_ext);
   assign in_tol = abs_diff <= {1'b0, TOLERANCE};
   assign over_limit = abs_act >= {1'b0, SUPERVISION_LIMIT};

   assign status_next[fcs_pkg::SW_READY_ON] = READY_ON;
   assign status_next[fcs_pkg::SW_READY_RUN] = READY_RUN;
   assign status_next[fcs_pkg::SW_OP_ENABLED] = OP_ENABLED;
   assign status_next[fcs_pkg::SW_FAULT] = FAULT_FLAG;
   assign status_next[fcs_pkg::SW_COAST_INACTIVE] = COAST_STOP_INACTIVE;
   assign status_next[fcs_pkg::SW_QUICK_INACTIVE] = QUICK_STOP_INACTIVE;
   assign status_next[fcs_pkg::SW_SWITCH_INHIBIT] = SWITCH_ON_INHIBITED;
   assign status_next[fcs_pkg::SW_ALARM] = ALARM;
   assign status_next[fcs_pkg::SW_TOLERANCE] = in_tol;
   assign status_next[fcs_pkg::SW_REMOTE] = REMOTE_CONTROL;
   assign status_next[fcs_pkg::SW_SUPERVISION] = over_limit;
   assign status_next[fcs_pkg::SW_NO_FAULT] = ~FAULT_FLAG;
   assign status_next[fcs_pkg::SW_RUN_ENABLE] = EXT_RUN_ENABLE;
   assign status_next[fcs_pkg::SW_LOCATION] = pump_cmd_reg[fcs_pkg::PC_LOCATION];
   assign status_next[fcs_pkg::SW_HEARTBEAT] = hb_wave;
   assign status_next[fcs_pkg::SW_RESERVED] = 1'b0;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         drive_cmd_reg <= fcs_pkg::CW_RESET;
         pump_cmd_reg <= fcs_pkg::PC_RESET;
         status_reg <= fcs_pkg::SW_RESET;
         gated_reg <= 7'h00;
      end else begin
         drive_cmd_reg <= drive_cmd_next;
         pump_cmd_reg <= pump_cmd_next;
         status_reg <= status_next;
         gated_reg <= gated_next;
      end
   end

   assign STATUS_WORD = status_reg;
   assign DRIVE_ENABLE = gated_reg[1];
   assign START_CMD = gated_reg[2];
   assign DIRECTION = gated_reg[3];
   assign CONST_SPEED_SEL = gated_reg[5:4];
   assign FAULT_RESET = gated_reg[6];
   assign HEARTBEAT_ECHO = drive_cmd_reg[fcs_pkg::CW_HEARTBEAT];
   assign EXTERNAL_LOCATION_SELECT = pump_cmd_reg[fcs_pkg::PC_LOCATION];
   assign PUMP_ENABLE = pump_cmd_reg[fcs_pkg::PC_PUMP_ENABLE];
   assign PUMP_FAULT_RESET = pump_cmd_reg[fcs_pkg::PC_PUMP_FAULT_RESET];
   assign RUNTIME_RESET = pump_cmd_reg[fcs_pkg::PC_RUNTIME_RESET];
   assign FLUID_LEVEL_LOOP_ENABLE = pump_cmd_reg[fcs_pkg::PC_LEVEL_LOOP];

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   a_ready_bit: assert property (##1 STATUS_WORD[0] == $past(READY_ON))
      else $error("Ready bit does not follow input");
   a_tol_bit: assert property ((REFERENCE_VALUE == ACTUAL_VALUE) |=> STATUS_WORD[8])
      else $error("Equal values not flagged within tolerance");
   a_remote_bit: assert property (REMOTE_CONTROL |=> STATUS_WORD[9])
      else $error("Remote bit missing");
   a_limit_bit: assert property (
      (ACTUAL_VALUE == 16'h0000 && SUPERVISION_LIMIT != 16'h0000) |=> !STATUS_WORD[10])
      else $error("Zero speed flagged supervision_exceeded");
   a_run_enable: assert property (##1 STATUS_WORD[12] == $past(EXT_RUN_ENABLE))
      else $error("Run enable bit does not follow input");
   a_location_bit: assert property (
      aux_hit |=> ##1 STATUS_WORD[13] == $past(RX_WORD[0], 2))
      else $error("Location bit does not follow pump command");
   a_heartbeat_step: assert property ($changed(STATUS_WORD[14]) |-> $past(hb_tick, 2))
      else $error("Heartbeat changed without divider tick");
   a_cmd_gate: assert property (!FIELDBUS_ACTIVE |=> !DRIVE_ENABLE && !START_CMD)
      else $error("Command acted without fieldbus control");
   a_cmd_capture: assert property (
      main_hit ##1 FIELDBUS_ACTIVE |=> START_CMD == $past(RX_WORD[3], 2))
      else $error("Start bit not taken from word one");
   a_reserved_zero: assert property (!STATUS_WORD[15] && !drive_cmd_reg[1])
      else $error("Reserved bit not zero");

   // Further status word checks
   a_tol_outside: assert property (
      (TOLERANCE == 16'h0000 && ACTUAL_VALUE != REFERENCE_VALUE) |=> !STATUS_WORD[8])
      else $error("Unequal values flagged within zero tolerance");
   a_remote_clear: assert property (!REMOTE_CONTROL |=> !STATUS_WORD[9])
      else $error("Remote bit set under local control");
   a_limit_zero: assert property (SUPERVISION_LIMIT == 16'h0000 |=> STATUS_WORD[10])
      else $error("Zero limit not flagged as reached");

   // Further command word checks
   a_echo_copy: assert property (main_hit |=> HEARTBEAT_ECHO == $past(RX_WORD[14]))
      else $error("Heartbeat echo not taken from command word");
   a_gate_flag: assert property (##1 gated_reg[0] == $past(FIELDBUS_ACTIVE))
      else $error("Fieldbus control flag not tracked");
   a_gate_rest: assert property (
      !FIELDBUS_ACTIVE |=> !DIRECTION && !FAULT_RESET && CONST_SPEED_SEL == 2'b00)
      else $error("Command fields acted without fieldbus control");
   a_pump_capture: assert property (
      aux_hit |=> {FLUID_LEVEL_LOOP_ENABLE, RUNTIME_RESET, PUMP_FAULT_RESET, PUMP_ENABLE,
         EXTERNAL_LOCATION_SELECT} == $past(RX_WORD[4:0]))
      else $error("Pump command not taken from word one");

   c_start: cover property (main_hit ##2 START_CMD);
   c_heartbeat: cover property ($rose(STATUS_WORD[14]));
   c_pump: cover property (aux_hit ##1 PUMP_ENABLE);
   c_limit: cover property (STATUS_WORD[10] && ACTUAL_VALUE[15]);
   c_gate_drop: cover property (FIELDBUS_ACTIVE ##1 !FIELDBUS_ACTIVE);
endmodule : fcs_top
`default_nettype wire

//--- fcs_ctrl_model.sv
// Fieldbus controller model that sends whole data sets and echoes the heartbeat
`timescale 1ns/1ns
`default_nettype none
module fcs_ctrl_model (
   input wire logic clk,
   input wire logic [15:0] status_word,
   output logic rx_valid,
   output logic [1:0] rx_set,
   output logic [1:0] rx_index,
   output logic [15:0] rx_word
);
   logic sent_echo = 1'b0;
   initial begin
      rx_valid = 1'b0;
      rx_set = 2'h0;
      rx_index = 2'h0;
      rx_word = 16'h0000;
   end
   // Three words per set, command in the first word
   task automatic send(input logic [1:0] set, input logic [15:0] cmd);
      logic [15:0] w;
      for (int i = 0; i < 3; i++) begin
         @(negedge clk);
         w = (i == 0) ? cmd : (16'h5a5a ^ 16'(i));
         if (i == 0 && set == 2'h1) begin
            w[14] = status_word[14];
            sent_echo = status_word[14];
         end
         rx_valid <= 1'b1;
         rx_set <= set;
         rx_index <= 2'(i);
         rx_word <= w;
      end
      @(negedge clk);
      rx_valid <= 1'b0;
      rx_set <= ~rx_set;
      rx_index <= ~rx_index;
      rx_word <= ~rx_word;
   endtask : send
endmodule : fcs_ctrl_model
`default_nettype wire

//--- fcs_top_tb.sv
// Self-checking testbench for the command and status word block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module fcs_top_tb;
   localparam int HB = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fb_act = 1'b0;
   logic [9:0] lv = 10'h000;
   logic [15:0] act = 16'h0000;
   logic [15:0] ref_v = 16'h0000;
   logic [15:0] tol = 16'h0000;
   logic [15:0] lim = 16'h0000;
   wire logic rx_valid;
   wire logic [1:0] rx_set;
   wire logic [1:0] rx_index;
   wire logic [15:0] rx_word;
   wire logic [15:0] status;
   wire logic [5:0] mo;
   wire logic [4:0] po;
   wire logic echo;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   fcs_top #(.HB_HALF_CYCLES(HB)) dut (.CLK(clk), .RST(rst), .RX_VALID(rx_valid),
      .RX_SET(rx_set), .RX_INDEX(rx_index), .RX_WORD(rx_word), .FIELDBUS_ACTIVE(fb_act),
      .READY_ON(lv[0]), .READY_RUN(lv[1]), .OP_ENABLED(lv[2]), .FAULT_FLAG(lv[3]),
      .COAST_STOP_INACTIVE(lv[4]), .QUICK_STOP_INACTIVE(lv[5]),
      .SWITCH_ON_INHIBITED(lv[6]), .ALARM(lv[7]), .ACTUAL_VALUE(act),
      .REFERENCE_VALUE(ref_v), .TOLERANCE(tol), .SUPERVISION_LIMIT(lim),
      .REMOTE_CONTROL(lv[8]), .EXT_RUN_ENABLE(lv[9]), .STATUS_WORD(status),
      .DRIVE_ENABLE(mo[5]), .START_CMD(mo[4]), .DIRECTION(mo[3]),
      .CONST_SPEED_SEL(mo[2:1]), .FAULT_RESET(mo[0]), .HEARTBEAT_ECHO(echo),
      .EXTERNAL_LOCATION_SELECT(po[4]), .PUMP_ENABLE(po[3]), .PUMP_FAULT_RESET(po[2]),
      .RUNTIME_RESET(po[1]), .FLUID_LEVEL_LOOP_ENABLE(po[0]));
   fcs_ctrl_model ctrl (.clk(clk), .status_word(status), .rx_valid(rx_valid),
      .rx_set(rx_set), .rx_index(rx_index), .rx_word(rx_word));
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         results();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic tol_case(input logic [15:0] a, r, t, l, input logic e8, e10);
      act = a;
      ref_v = r;
      tol = t;
      lim = l;
      tick(2);
      `CHK(status[8], e8)
      `CHK(status[10], e10)
   endtask : tol_case
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   initial begin : main
      logic [15:0] exp_w;
      logic hb;
      int n;
      tick(1);
      `CHK(status, fcs_pkg::SW_RESET)
      tick(19);
      rst = 1'b0;
      for (int i = 0; i < 11; i++) begin
         lv = (i == 10) ? 10'h3ff : (10'h001 << i);
         tick(2);
         exp_w = {1'b0, 2'b00, lv[9], ~lv[3], 1'b0, lv[8], 1'b0, lv[7:0]};
         `CHK(status & 16'h9aff, exp_w)
      end
      $display("test status bits done");
      fb_act = 1'b1;
      ctrl.send(2'h1, 16'h8029);
      tick(1);
      `CHK(mo, 6'h32)
      `CHK(echo, ctrl.sent_echo)
      ctrl.send(2'h1, 16'hbfd6);
      tick(1);
      `CHK(mo, 6'h0d)
      `CHK(echo, ctrl.sent_echo)
      fb_act = 1'b0;
      tick(2);
      `CHK(mo, 6'h00)
      fb_act = 1'b1;
      tick(2);
      `CHK(mo, 6'h0d)
      $display("test main command done");
      ctrl.send(2'h3, 16'hffea);
      tick(1);
      `CHK(po, 5'h0a)
      `CHK(status[13], 1'b0)
      ctrl.send(2'h3, 16'h8013);
      tick(1);
      `CHK(po, 5'h19)
      `CHK(status[13], 1'b1)
      ctrl.send(2'h2, 16'h0000);
      tick(1);
      `CHK(po, 5'h19)
      $display("test pump command done");
      tol_case(16'h0064, 16'h005a, 16'h000a, 16'h0064, 1'b1, 1'b1);
      tol_case(16'h0064, 16'h005a, 16'h0009, 16'h0065, 1'b0, 1'b0);
      tol_case(16'hffce, 16'hffd8, 16'h000a, 16'h0032, 1'b1, 1'b1);
      tol_case(16'hffcf, 16'h0000, 16'h0030, 16'h0032, 1'b0, 1'b0);
      tol_case(16'h0001, 16'h0000, 16'h0000, 16'h8000, 1'b0, 1'b0);
      $display("test tolerance and limit done");
      for (int k = 0; k < 2; k++) begin
         hb = status[14];
         n = 0;
         while (status[14] === hb && n < 40) begin
            tick(1);
            n++;
         end
      end
      `CHK(n, HB)
      $display("test heartbeat done");
      results();
   end
endmodule : fcs_top_tb
`default_nettype wire
